//--- core/msp_pkg.sv
// Package for the mode/sync decoder, clock lock sequencer and power-good flag logic.
// Assumes the switching clock domain runs faster than any sync pulse on the mode pin.

package msp_pkg;

   // ==========================================================
   // Sequence figures.
   localparam int MSP_CW = 16;
   localparam logic [11:0] MSP_CTL_PULSES = 12'h004;
   localparam logic [11:0] MSP_LOCK_PULSES = 12'h800;
   localparam logic [11:0] MSP_DBL_EDGES = 12'h002;
   localparam logic [11:0] MSP_PHASE_STEPS = 12'h020;
   localparam logic [11:0] MSP_CNT_MAX = 12'hfff;

   // ==========================================================
   // Default counts in switching clock cycles.
   localparam logic [MSP_CW-1:0] MSP_DEF_PERIOD = 16'h0018;
   localparam logic [MSP_CW-1:0] MSP_PER_MIN = 16'h0008;
   localparam logic [MSP_CW-1:0] MSP_PER_MAX = 16'h0080;
   localparam logic [MSP_CW-1:0] MSP_HI_MIN = 16'h0002;
   localparam logic [MSP_CW-1:0] MSP_SETTLE = 16'h0100;
   localparam logic [MSP_CW-1:0] MSP_FALL = 16'h0020;
   localparam logic [MSP_CW-1:0] MSP_RISE = 16'h0040;
   localparam logic [MSP_CW-1:0] MSP_SS_MAX = 16'h2000;

   // ==========================================================
   // Input bit positions in the synchroniser bank.
   localparam int MSP_NIN = 10;
   localparam int MSP_I_PIN = 0;
   localparam int MSP_I_SLOW = 1;

   // Lock sequencer, Gray coded along the usual path.
   typedef enum logic [2:0] {
      MSP_ST_IDLE = 3'h0,
      MSP_ST_COUNT = 3'h1,
      MSP_ST_ADJ = 3'h3,
      MSP_ST_PHASE = 3'h2,
      MSP_ST_LOCKED = 3'h6
   } msp_state_e;

   // Operating mode report.
   typedef struct packed {
      logic pulse_ctl;
      logic forced_pwm_mode;
      logic sync_on;
      logic spread_on;
      logic freq_lock;
      logic phase_lock;
      logic power_ok_flag;
      logic switch_inhibit;
   } msp_mode_s;

   // Power-good comparator and supervisor inputs.
   typedef struct packed {
      logic uv_trip;
      logic ov_trip;
      logic in_reg;
      logic temp_hot;
      logic temp_cool;
      logic en_ok;
      logic vcc_ok;
      logic vout_full;
   } msp_pg_s;

endpackage

//--- core/msp_core.sv
// Mode/sync decoding, sync clock lock and power-good flag, in one module.
// Assumes all analog comparators deliver logic levels unrelated to either clock.
`timescale 1ns/1ps
`default_nettype none

module msp_core
   import msp_pkg::*;
#(
   parameter logic [MSP_CW-1:0] DEF_PERIOD = MSP_DEF_PERIOD,
   parameter logic [MSP_CW-1:0] PER_MIN = MSP_PER_MIN,
   parameter logic [MSP_CW-1:0] PER_MAX = MSP_PER_MAX,
   parameter logic [MSP_CW-1:0] HI_MIN = MSP_HI_MIN,
   parameter logic [MSP_CW-1:0] SETTLE_CYC = MSP_SETTLE,
   parameter logic [MSP_CW-1:0] FALL_CYC = MSP_FALL,
   parameter logic [MSP_CW-1:0] RISE_CYC = MSP_RISE,
   parameter logic [MSP_CW-1:0] SS_MAX_CYC = MSP_SS_MAX
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sw_clk,
   input wire logic mode_sync_in,
   input wire logic freq_slowed,
   input wire msp_pg_s pg_in,
   input wire logic power_ok_flag_in,
   output logic power_ok_flag_out,
   output logic power_ok_flag_oe_n,
   output msp_mode_s sw_mode,
   output logic [MSP_CW-1:0] sw_period,
   output logic phase_step,
   output msp_mode_s sys_mode,
   output logic sys_flag_level
);

   // ==========================================================
   // Reset release, one synchroniser per domain.
   logic [1:0] rsw_q;
   logic [1:0] rsys_q;
   logic rst_sw;
   logic rst_sys;

   // Assert at once, release on the domain's own clock.
   always_ff @(posedge sw_clk or posedge rst)
   begin
      if (rst)
         rsw_q <= 2'h3;
      else
         rsw_q <= {rsw_q[0], 1'b0};
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rsys_q <= 2'h3;
      else
         rsys_q <= {rsys_q[0], 1'b0};
   end

   assign rst_sw = rsw_q[1];
   assign rst_sys = rsys_q[1];

   // ==========================================================
   // Input synchronisers: three stages, a change counts when stages two and three agree.
   logic [MSP_NIN-1:0] raw;
   logic [MSP_NIN-1:0] s1;
   logic [MSP_NIN-1:0] s2;
   logic [MSP_NIN-1:0] s3;
   logic [MSP_NIN-1:0] filt;

   assign raw = {pg_in, freq_slowed, mode_sync_in};

   // Stage one feeds only stage two, so no metastable value leaks out.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
      end
      else
      begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < MSP_NIN; i++)
            if (s2[i] == s3[i])
               filt[i] <= s3[i];
      end
   end

   logic pin;
   logic slowed;
   msp_pg_s pg;
   assign pin = filt[MSP_I_PIN];
   assign slowed = filt[MSP_I_SLOW];
   assign pg = filt[MSP_NIN-1:2];

   // ==========================================================
   // Pin timing: period, high width and settle counters.
   logic pin_q;
   logic rise_e;
   logic [MSP_CW-1:0] per_cnt;
   logic [MSP_CW-1:0] hi_cnt;
   logic [MSP_CW-1:0] idle_cnt;
   logic hi_ok;
   logic settle;
   logic iv_ok;

   assign rise_e = pin & ~pin_q;
   assign settle = (idle_cnt == SETTLE_CYC);
   assign iv_ok = rise_e && hi_ok && (per_cnt >= PER_MIN) && (per_cnt <= PER_MAX);

   // Counters saturate so a dead pin never wraps; settle fires once, one cycle per steady level.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         pin_q <= 1'b0;
         per_cnt <= '0;
         hi_cnt <= '0;
         idle_cnt <= '0;
         hi_ok <= 1'b0;
      end
      else
      begin
         pin_q <= pin;
         if (pin != pin_q)
            idle_cnt <= '0;
         else if (idle_cnt <= SETTLE_CYC)
            idle_cnt <= idle_cnt + 1'b1;
         if (rise_e)
            per_cnt <= MSP_CW'(1); // The edge cycle counts, so the count equals the period.
         else if (per_cnt != '1)
            per_cnt <= per_cnt + 1'b1;
         if (rise_e)
            hi_cnt <= '0;
         else if (pin && hi_cnt != '1)
            hi_cnt <= hi_cnt + 1'b1;
         if (!pin && pin_q)
            hi_ok <= (hi_cnt >= HI_MIN);
      end
   end

   // ==========================================================
   // Pulse train counters.
   logic [11:0] train_cnt;
   logic [11:0] burst_cnt;
   logic dbl_ok;
   logic [MSP_CW-1:0] last_per;

   // A bad interval restarts the train; a settle closes the burst.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         train_cnt <= '0;
         burst_cnt <= '0;
         dbl_ok <= 1'b0;
         last_per <= DEF_PERIOD;
      end
      else
      begin
         if (iv_ok)
         begin
            if (train_cnt != MSP_CNT_MAX)
               train_cnt <= train_cnt + 1'b1;
            last_per <= per_cnt;
         end
         else if (rise_e || settle)
            train_cnt <= '0;
         if (settle)
            burst_cnt <= '0;
         else if (rise_e && burst_cnt != MSP_CNT_MAX)
            burst_cnt <= burst_cnt + 1'b1;
         if (settle)
            dbl_ok <= 1'b0;
         else if (rise_e)
            dbl_ok <= (burst_cnt == 12'h001) && iv_ok;
      end
   end

   // ==========================================================
   // Lock sequencer and mode outputs.
   msp_state_e st;
   logic [11:0] ph_cnt;
   logic [MSP_CW-1:0] mid_per;
   logic [MSP_CW:0] per_sum;

   assign per_sum = {1'b0, sw_period} + {1'b0, last_per};
   assign mid_per = per_sum[MSP_CW:1];

   // The period steps through the midpoint for one cycle, the phase is then walked in one edge at a time.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         st <= MSP_ST_IDLE;
         ph_cnt <= '0;
         sw_period <= DEF_PERIOD;
         phase_step <= 1'b0;
      end
      else
      begin
         phase_step <= 1'b0;
         if (settle)
         begin
            st <= MSP_ST_IDLE;
            sw_period <= DEF_PERIOD;
         end
         else
            case (st)
               MSP_ST_IDLE:
                  if (iv_ok)
                     st <= MSP_ST_COUNT;
               MSP_ST_COUNT:
                  if (rise_e && !iv_ok)
                     st <= MSP_ST_IDLE;
                  else if (train_cnt >= MSP_LOCK_PULSES && !slowed)
                     st <= MSP_ST_ADJ;
               MSP_ST_ADJ:
               begin
                  sw_period <= mid_per;
                  ph_cnt <= '0;
                  st <= MSP_ST_PHASE;
               end
               MSP_ST_PHASE:
               begin
                  sw_period <= last_per;
                  if (rise_e)
                  begin
                     phase_step <= 1'b1;
                     ph_cnt <= ph_cnt + 1'b1;
                     if (ph_cnt == MSP_PHASE_STEPS - 12'h001)
                        st <= MSP_ST_LOCKED;
                  end
               end
               MSP_ST_LOCKED:
                  sw_period <= last_per;
               default:
                  st <= MSP_ST_IDLE;
            endcase
      end
   end

   // Mode flags: pulse control is sticky until restart.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         sw_mode.pulse_ctl <= 1'b0;
         sw_mode.forced_pwm_mode <= 1'b0;
         sw_mode.sync_on <= 1'b0;
         sw_mode.spread_on <= 1'b0;
         sw_mode.freq_lock <= 1'b0;
         sw_mode.phase_lock <= 1'b0;
      end
      else
      begin
         if (train_cnt >= MSP_CTL_PULSES)
            sw_mode.pulse_ctl <= 1'b1;
         if (settle)
         begin
            sw_mode.forced_pwm_mode <= pin;
            sw_mode.sync_on <= 1'b0;
            sw_mode.freq_lock <= 1'b0;
            sw_mode.phase_lock <= 1'b0;
            sw_mode.spread_on <= !(sw_mode.pulse_ctl && dbl_ok &&
               burst_cnt == MSP_DBL_EDGES);
         end
         else if (st == MSP_ST_ADJ)
         begin
            sw_mode.sync_on <= 1'b1;
            sw_mode.forced_pwm_mode <= 1'b1;
            sw_mode.spread_on <= 1'b0;
            sw_mode.freq_lock <= 1'b1;
         end
         else if (rise_e && !sw_mode.sync_on && burst_cnt == '0)
            sw_mode.spread_on <= 1'b1;
         if (st == MSP_ST_LOCKED)
            sw_mode.phase_lock <= 1'b1;
      end
   end

   // ==========================================================
   // Power-good faults, filters and soft start.
   logic [MSP_CW-1:0] uv_cnt;
   logic [MSP_CW-1:0] ov_cnt;
   logic [MSP_CW-1:0] rise_cnt;
   logic [MSP_CW-1:0] ss_cnt;
   logic uv_fault;
   logic ov_fault;
   logic tsd_fault;
   logic en_fault;
   logic vcc_fault;
   logic ss_run;
   logic up_q;
   logic any_fault;

   assign any_fault = uv_fault | ov_fault | tsd_fault | en_fault | vcc_fault | ss_run;

   // Short undervoltage and overvoltage excursions only run the filter counter; a fault clears only in regulation.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         uv_cnt <= '0;
         ov_cnt <= '0;
         uv_fault <= 1'b0;
         ov_fault <= 1'b0;
         tsd_fault <= 1'b0;
         en_fault <= 1'b1;
         vcc_fault <= 1'b1;
      end
      else
      begin
         uv_cnt <= pg.uv_trip ? (uv_cnt == FALL_CYC ? uv_cnt : uv_cnt + 1'b1) : '0;
         ov_cnt <= pg.ov_trip ? (ov_cnt == FALL_CYC ? ov_cnt : ov_cnt + 1'b1) : '0;
         if (pg.uv_trip && uv_cnt == FALL_CYC)
            uv_fault <= 1'b1;
         else if (pg.in_reg)
            uv_fault <= 1'b0;
         if (pg.ov_trip && ov_cnt == FALL_CYC)
            ov_fault <= 1'b1;
         else if (pg.in_reg)
            ov_fault <= 1'b0;
         if (pg.temp_hot)
            tsd_fault <= 1'b1;
         else if (pg.temp_cool && pg.in_reg)
            tsd_fault <= 1'b0;
         if (!pg.en_ok)
            en_fault <= 1'b1;
         else if (pg.in_reg)
            en_fault <= 1'b0;
         if (!pg.vcc_ok)
            vcc_fault <= 1'b1;
         else if (pg.in_reg)
            vcc_fault <= 1'b0;
      end
   end

   // Soft start begins whenever the converter becomes able to run.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         up_q <= 1'b0;
         ss_run <= 1'b0;
         ss_cnt <= '0;
      end
      else
      begin
         up_q <= pg.en_ok & pg.vcc_ok & ~tsd_fault;
         if (pg.en_ok && pg.vcc_ok && !tsd_fault && !up_q)
         begin
            ss_run <= 1'b1;
            ss_cnt <= '0;
         end
         else if (ss_run)
         begin
            ss_cnt <= ss_cnt + 1'b1;
            if (pg.vout_full || ss_cnt == SS_MAX_CYC)
               ss_run <= 1'b0;
         end
      end
   end

   // Release waits a full rise filter; the direct terms drop the flag at once.
   always_ff @(posedge sw_clk or posedge rst_sw)
   begin
      if (rst_sw)
      begin
         rise_cnt <= '0;
         sw_mode.power_ok_flag <= 1'b0;
         sw_mode.switch_inhibit <= 1'b1;
      end
      else
      begin
         sw_mode.switch_inhibit <= ~pg.vcc_ok;
         if (any_fault || !pg.en_ok || !pg.vcc_ok)
         begin
            rise_cnt <= '0;
            sw_mode.power_ok_flag <= 1'b0;
         end
         else if (rise_cnt != RISE_CYC)
            rise_cnt <= rise_cnt + 1'b1;
         else
            sw_mode.power_ok_flag <= 1'b1;
      end
   end

   // Open drain: enable low while pulling the pin low.
   assign power_ok_flag_out = 1'b0;
   assign power_ok_flag_oe_n = sw_mode.power_ok_flag;

   // ==========================================================
   // Status levels into the system clock domain, two stages each.
   msp_mode_s xm1;
   logic xf1;

   always_ff @(posedge sys_clk or posedge rst_sys)
   begin
      if (rst_sys)
      begin
         xm1 <= '0;
         sys_mode <= '0;
         xf1 <= 1'b0;
         sys_flag_level <= 1'b0;
      end
      else
      begin
         xm1 <= sw_mode;
         sys_mode <= xm1;
         xf1 <= power_ok_flag_in;
         sys_flag_level <= xf1;
      end
   end

   // ==========================================================
   // Checks in the switching clock domain.
   default clocking cb @(posedge sw_clk);
   endclocking
   default disable iff (rst_sw);

   sequence seq_step;
      sw_period == $past(mid_per) ##1 sw_period == $past(last_per);
   endsequence

   a_ctl_sticky: assert property (sw_mode.pulse_ctl |=> sw_mode.pulse_ctl)
      else $error("pulse control dropped without restart");
   a_sync_late: assert property ($rose(sw_mode.sync_on) |-> $past(train_cnt, 2) >= MSP_LOCK_PULSES)
      else $error("sync mode entered too early");
   a_settle_exit: assert property (settle |=> !sw_mode.sync_on
      && sw_mode.forced_pwm_mode == $past(pin))
      else $error("steady pin did not select level mode");
   a_spread_back: assert property (settle && !dbl_ok |=> sw_mode.spread_on)
      else $error("spread spectrum not restored");
   a_freq_step: assert property (st == MSP_ST_ADJ && !settle |=> !sw_mode.spread_on ##0 seq_step)
      else $error("transitional period or spread wrong");
   a_slow_defer: assert property (slowed && st == MSP_ST_COUNT |=> st != MSP_ST_ADJ)
      else $error("lock taken while clock slowed");
   a_uv_filter: assert property ($rose(uv_fault) |-> $past(uv_cnt) == FALL_CYC)
      else $error("undervoltage tripped before fall filter");
   a_en_low: assert property (!pg.en_ok |=> !sw_mode.power_ok_flag ##1 !sw_mode.power_ok_flag)
      else $error("flag not forced low by enable");
   a_rise_wait: assert property ($rose(sw_mode.power_ok_flag) |-> $past(rise_cnt) == RISE_CYC
      && !$past(any_fault))
      else $error("flag released before rise filter");
   a_vcc_lock: assert property (!pg.vcc_ok |=> sw_mode.switch_inhibit && !sw_mode.power_ok_flag)
      else $error("lockout did not inhibit");

endmodule

`default_nettype wire

//--- bench/msp_host_model.sv
// Host-side model: drives the mode/sync pin and reads the open-drain power-good line.
// Assumes the switching clock paces all pin activity; the pin changes just after its edges.
`timescale 1ns/1ps
`default_nettype none

module msp_host_model
(
   input wire logic sw_clk,
   input wire logic flag_drv,
   input wire logic flag_oe_n,
   output var logic mode_pin,
   output logic flag_pin
);

   // ==========================================================
   // Open-drain line with a pull-up, so a released line reads high.
   assign flag_pin = flag_oe_n ? 1'b1 : flag_drv;

   // The pin idles low until the bench asks for something else.
   initial mode_pin = 1'b0;

   // ==========================================================
   // Pulse trains: each pulse is a low phase then a high phase of hi cycles.
   // Callers keep per and hi inside the valid sync window.
   task automatic pulses(input int n, input int per, input int hi);
      for (int i = 0; i < n; i++)
      begin
         mode_pin = 1'b0;
         repeat (per - hi) @(posedge sw_clk);
         #1;
         mode_pin = 1'b1;
         repeat (hi) @(posedge sw_clk);
         #1;
      end
   endtask

   // Steady level on the pin; held long enough it selects a mode.
   task automatic set_level(input logic lvl);
      mode_pin = lvl;
   endtask

endmodule

`default_nettype wire

//--- bench/tb_mode_sync_lock_and_power_good.sv
// Self-checking bench for the mode/sync decoder, clock lock and power-good flag.
// Assumes msp_pkg and msp_core are compiled first; counts are shortened by parameters.
`timescale 1ns/1ps
`default_nettype none

module tb_mode_sync_lock_and_power_good;
   import msp_pkg::*;

   // ==========================================================
   // Shortened counts so the run stays brief.
   localparam logic [MSP_CW-1:0] RISE = 16'h0008;
   logic sys_clk, rst, sw_clk, freq_slowed, flag_pin, mode_pin, flag_out, flag_oe_n;
   logic phase_step, sys_flag_level, last_sync;
   logic [MSP_CW-1:0] sw_period, last_per;
   logic [MSP_CW-1:0] period_q[$];
   msp_pg_s pg;
   msp_mode_s sw_mode, sys_mode;
   msp_pg_s fault_tab [5] = '{8'h8f, 8'h4f, 8'h37, 8'h2b, 8'h2d};
   int failures, total_checks, steps, per, g;

   // Two unrelated clocks: 100 ns system, 6 ns switching.
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial
   begin
      sw_clk = 1'b0;
      #1.3;
      forever #3 sw_clk = ~sw_clk;
   end

   msp_core #(.SETTLE_CYC(16'h0010), .FALL_CYC(16'h0004), .RISE_CYC(RISE),
      .SS_MAX_CYC(16'h0020)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .sw_clk(sw_clk), .mode_sync_in(mode_pin),
      .freq_slowed(freq_slowed), .pg_in(pg), .power_ok_flag_in(flag_pin),
      .power_ok_flag_out(flag_out), .power_ok_flag_oe_n(flag_oe_n), .sw_mode(sw_mode),
      .sw_period(sw_period), .phase_step(phase_step), .sys_mode(sys_mode),
      .sys_flag_level(sys_flag_level));

   msp_host_model i_host (.sw_clk(sw_clk), .flag_drv(flag_out), .flag_oe_n(flag_oe_n),
      .mode_pin(mode_pin), .flag_pin(flag_pin));

   // ==========================================================
   // Reference record, sampled mid-cycle where the registered outputs have settled.
   always @(negedge sw_clk)
   begin
      if (phase_step === 1'b1)
         steps = steps + 1;
      if (sw_mode.sync_on === 1'b1 && (last_sync !== 1'b1 || sw_period !== last_per))
         period_q.push_back(sw_period);
      last_sync = sw_mode.sync_on;
      last_per = sw_period;
   end

   // ==========================================================
   // Shared helpers; cyc returns 1 ns after a switching edge, so inputs set after it land there.
   task automatic cyc(input int n);
      repeat (n) @(posedge sw_clk);
      #1;
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (failures == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog a margin beyond the roughly 0.28 ms the sequence needs.
   initial
   begin
      #400000;
      failures++;
      $display("Error %0t: run did not finish", $time);
      wrap_up();
   end

   // ==========================================================
   // Main sequence.
   initial
   begin
      failures = 0;
      total_checks = 0;
      steps = 0;
      rst = 1'b1;
      freq_slowed = 1'b0;
      pg = 8'h00;
      last_sync = 1'b0;
      last_per = '0;
      g = $urandom(20);
      repeat (10) @(posedge sys_clk);
      #1;
      chk16({8'h00, sw_mode}, 16'h0001, "reset mode");
      chk16(sw_period, MSP_DEF_PERIOD, "reset period");
      chk1(flag_oe_n, 1'b0, "reset pull");
      chk1(flag_out, 1'b0, "drive value");
      rst = 1'b0;
      cyc(6);
      // Soft start without full output ends only at the maximum time.
      pg = 8'h2e;
      cyc(30);
      chk1(sw_mode.power_ok_flag, 1'b0, "soft start");
      chk1(sw_mode.switch_inhibit, 1'b0, "supply ok");
      cyc(60);
      chk1(sw_mode.power_ok_flag, 1'b1, "soft start end");
      chk1(sw_mode.forced_pwm_mode, 1'b0, "low level");
      chk1(sw_mode.spread_on, 1'b1, "level spread");
      pg = 8'h2f;
      // Every fault kind: short excursions first where a filter applies.
      for (int k = 0; k < 5; k++)
      begin
         if (k < 2)
         begin
            g = 1 + $urandom % 3;
            pg = fault_tab[k];
            cyc(g);
            pg = 8'h2f;
            cyc(20);
            chk1(sw_mode.power_ok_flag, 1'b1, "short excursion");
         end
         pg = fault_tab[k];
         cyc(15);
         chk1(sw_mode.power_ok_flag, 1'b0, "fault");
         chk1(flag_pin, 1'b0, "pin under fault");
         if (k == 4)
            chk1(sw_mode.switch_inhibit, 1'b1, "lockout");
         if (k == 2)
         begin
            pg = 8'h27;
            cyc(30);
            chk1(sw_mode.power_ok_flag, 1'b0, "still warm");
         end
         pg = 8'h2f;
         cyc(RISE);
         chk1(sw_mode.power_ok_flag, 1'b0, "rise filter");
         cyc(40);
         chk1(sw_mode.power_ok_flag, 1'b1, "released");
         repeat (3) @(posedge sys_clk);
         #1;
         chk1(sys_flag_level, 1'b1, "pin read back");
      end
      // Sync train: control switch, deferral, then frequency and phase lock.
      per = 10 + $urandom % 11;
      cyc(1);
      i_host.pulses(3, per, 4);
      chk1(sw_mode.pulse_ctl, 1'b0, "early pulses");
      chk1(sw_mode.spread_on, 1'b1, "train spread");
      i_host.pulses(5, per, 4);
      chk1(sw_mode.pulse_ctl, 1'b1, "pulse control");
      i_host.pulses(2030, per, 4);
      chk1(sw_mode.sync_on, 1'b0, "before count");
      chk1(sw_mode.freq_lock, 1'b0, "no lock yet");
      freq_slowed = 1'b1;
      i_host.pulses(40, per, 4);
      chk1(sw_mode.freq_lock, 1'b0, "slowed lock");
      chk1(sw_mode.spread_on, 1'b1, "slowed spread");
      period_q.delete();
      steps = 0;
      freq_slowed = 1'b0;
      i_host.pulses(80, per, 4);
      chk16(16'(period_q.size()), 16'h0002, "period steps");
      chk16(period_q[0], MSP_CW'((int'(MSP_DEF_PERIOD) + per) / 2), "between");
      chk16(period_q[1], MSP_CW'(per), "sync period");
      chk1(sw_mode.sync_on, 1'b1, "sync mode");
      chk1(sw_mode.freq_lock, 1'b1, "freq lock");
      chk1(sw_mode.spread_on, 1'b0, "sync spread");
      chk1(sw_mode.phase_lock, 1'b1, "phase lock");
      chk16(MSP_CW'(steps), {4'h0, MSP_PHASE_STEPS}, "phase steps");
      // Steady levels leave sync mode.
      i_host.set_level(1'b1);
      cyc(30);
      chk1(sw_mode.sync_on, 1'b0, "leave sync");
      chk1(sw_mode.forced_pwm_mode, 1'b1, "high level");
      chk1(sw_mode.spread_on, 1'b1, "spread back");
      chk1(sw_mode.pulse_ctl, 1'b1, "pulse kept");
      chk16(sw_period, MSP_DEF_PERIOD, "default period");
      i_host.set_level(1'b0);
      cyc(30);
      chk1(sw_mode.forced_pwm_mode, 1'b0, "low level");
      // Double pulse then a level: that mode without spread.
      for (int lvl = 1; lvl >= 0; lvl--)
      begin
         i_host.pulses(2, per, 4);
         i_host.set_level(lvl[0]);
         cyc(30);
         chk1(sw_mode.forced_pwm_mode, lvl[0], "double mode");
         chk1(sw_mode.spread_on, 1'b0, "double spread");
      end
      i_host.pulses(1, per, 4);
      cyc(4);
      chk1(sw_mode.spread_on, 1'b1, "first edge spread");
      repeat (3) @(posedge sys_clk);
      #1;
      chk1(sys_mode.pulse_ctl, 1'b1, "sys pulse");
      chk1(sys_mode.power_ok_flag, 1'b1, "sys flag");
      // Restart returns to level control.
      rst = 1'b1;
      cyc(3);
      chk16({8'h00, sw_mode}, 16'h0001, "restart mode");
      chk1(flag_oe_n, 1'b0, "restart pull");
      rst = 1'b0;
      cyc(40);
      chk1(sw_mode.pulse_ctl, 1'b0, "level control");
      wrap_up();
   end

endmodule

`default_nettype wire
